// [src/phase_zone_sequencer.sv]
// Supervisory logic of a multiphase buck controller: straps, soft start, power-good, zones, phase one drive.
// Assumes pin inputs are asynchronous; the converter handshake and modulator input share clk.
`timescale 1ns/1ps
`default_nettype none
`include "phase_zone_defines.svh"
module phase_zone_sequencer #(
	parameter int INIT_CYC = `INIT_CYC,
	parameter int RAMP_STEP_CYC = `RAMP_STEP_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic vcc_uvlo,
	input wire logic ramp_supply_sense,
	input wire logic ovp_fault,
	input wire logic uvp_fault,
	input wire logic in_regulation,
	input wire logic psi_above_low,
	input wire logic psi_above_mid,
	input wire logic zero_current_detect,
	input wire logic [7:0] phase_sense_pos,
	input wire logic first_phase_drive_on,
	input wire logic adc_done,
	input wire logic [7:0] adc_data,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic adc_start,
	output logic [2:0] adc_sel,
	output logic test_current_en,
	output logic power_good_out,
	output logic soft_start_ramp,
	output logic [7:0] phase_enable,
	output logic diode_emulation,
	output phase_zone_pkg::level_e first_phase_drive,
	output logic [7:0] zcd_threshold,
	output logic sda_out,
	output logic sda_oe
);
	import phase_zone_pkg::*;

	logic [18:0] raw, s1_q, s2_q, s3_q, pin_q;
	logic en_s, uvlo_s, rok_s, ovp_s, uvp_s, reg_s, plo_s, pmid_s, zcd_s, scl_s, sda_s;
	logic [7:0] csp_s;

	assign raw = {enable, vcc_uvlo, ramp_supply_sense, ovp_fault, uvp_fault, in_regulation,
		psi_above_low, psi_above_mid, zero_current_detect, scl_in, sda_in, phase_sense_pos};

	// A pin change is taken once the second and third stages agree.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else if (ce) begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
		end
	end

	assign {en_s, uvlo_s, rok_s, ovp_s, uvp_s, reg_s, plo_s, pmid_s, zcd_s, scl_s, sda_s, csp_s} = pin_q;

	seq_e seq_q;
	bus_e bus_q;
	psi_e psi_q, psi_now;
	logic [19:0] tmr_q;
	logic [15:0] shed_q;
	logic [2:0] sidx_q;
	logic busy_q, strapped_q, cold_q, power_good_out_q;
	logic [1:0] ramp_sel_q;
	logic [7:0] mask_q, phase_en_q;
	byte_t zone_a_q, zone_b_q, zcd_th_q, zcd_ctl_q, load_current_sense_q;
	logic [3:0][7:0] th_q;
	level_e drive_q;
	logic de_q;
	logic strap_cap, strap_done, fault, active, init_end, ramp_end;
	logic scl_d_q, sda_d_q, scl_rise, scl_fall, bus_start, bus_stop, wr_stb, rw_q;
	logic [3:0] bcnt_q;
	logic [1:0] bidx_q;
	byte_t sh_q, ptr_q;
	zone_if zif();

	zone_select u_zone (
		.zif(zif)
	);

	function automatic zone_t strap_zone(input byte_t code);
		if (code < `ZB1) strap_zone = 3'h0;
		else if (code < `ZB2) strap_zone = 3'h1;
		else if (code < `ZB3) strap_zone = 3'h2;
		else if (code < `ZB4) strap_zone = 3'h3;
		else strap_zone = `ZONE_MAX;
	endfunction

	function automatic logic [19:0] ramp_cycles(input logic [1:0] sel);
		ramp_cycles = 20'(RAMP_STEP_CYC * (int'(sel) + 1));
	endfunction

	function automatic byte_t rd_reg(input byte_t a);
		if (a == `REG_PHASE_STAT) rd_reg = mask_q;
		else if (a == `REG_ZONE_A) rd_reg = zone_a_q;
		else if (a == `REG_ZONE_B) rd_reg = zone_b_q;
		else if (a >= `REG_SHED_TH1 && a <= `REG_SHED_TH4) rd_reg = th_q[a[1:0]];
		else if (a == `REG_ZCD_TH) rd_reg = zcd_th_q;
		else if (a == `REG_ZCD_CTL) rd_reg = zcd_ctl_q;
		else if (a == `REG_STATUS) rd_reg = {2'h0, de_q, cold_q, power_good_out_q, zif.zone};
		else rd_reg = 8'h00;
	endfunction

	always_comb begin
		if (pmid_s) psi_now = PSI_HIGH;
		else if (plo_s) psi_now = PSI_MID;
		else psi_now = PSI_LOW;
	end

	assign strap_cap = (seq_q == SEQ_STRAP) && busy_q && adc_done;
	assign strap_done = strap_cap && (sidx_q == `SEL_RAMP);
	assign fault = ovp_s || uvp_s || !rok_s;
	assign active = (seq_q == SEQ_INIT) || (seq_q == SEQ_RAMP) || (seq_q == SEQ_RUN);
	assign init_end = (seq_q == SEQ_INIT) && (tmr_q == 20'(INIT_CYC - 1));
	assign ramp_end = (seq_q == SEQ_RAMP) && (tmr_q == ramp_cycles(ramp_sel_q) - 20'h1);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_q <= SEQ_OFF;
		end else if (ce) begin
			if (uvlo_s) begin
				seq_q <= SEQ_OFF;
			end else begin
				unique case (seq_q)
					SEQ_OFF: if (en_s) seq_q <= strapped_q ? SEQ_INIT : SEQ_STRAP;
					SEQ_STRAP: if (strap_done) seq_q <= SEQ_INIT;
					SEQ_INIT: begin
						if (!en_s) seq_q <= SEQ_OFF;
						else if (fault) seq_q <= SEQ_FAULT;
						else if (init_end) seq_q <= SEQ_RAMP;
					end
					SEQ_RAMP: begin
						if (!en_s) seq_q <= SEQ_OFF;
						else if (fault) seq_q <= SEQ_FAULT;
						else if (ramp_end) seq_q <= SEQ_RUN;
					end
					SEQ_RUN: begin
						if (!en_s) seq_q <= SEQ_OFF;
						else if (fault) seq_q <= SEQ_FAULT;
					end
					SEQ_FAULT: if (!en_s) seq_q <= SEQ_OFF;
					default: seq_q <= SEQ_OFF;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tmr_q <= '0;
		end else if (ce) begin
			if (init_end || (seq_q != SEQ_INIT && seq_q != SEQ_RAMP)) tmr_q <= '0;
			else tmr_q <= tmr_q + 20'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_good_out_q <= 1'b0;
		end else if (ce) begin
			if (uvlo_s || seq_q == SEQ_FAULT) power_good_out_q <= 1'b0;
			else if (seq_q == SEQ_STRAP || seq_q == SEQ_INIT || seq_q == SEQ_RAMP) power_good_out_q <= 1'b0;
			else if (seq_q == SEQ_RUN && reg_s) power_good_out_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cold_q <= 1'b1;
			strapped_q <= 1'b0;
		end else if (ce) begin
			if (uvlo_s) begin
				cold_q <= 1'b1;
				strapped_q <= 1'b0;
			end else begin
				if (strap_done) strapped_q <= 1'b1;
				if ((seq_q == SEQ_RUN || seq_q == SEQ_FAULT) && !en_s) cold_q <= 1'b0;
			end
		end
	end

	// The select level is frozen from enable until power-good is high.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			psi_q <= PSI_HIGH;
		end else if (ce) begin
			if (seq_q == SEQ_OFF && en_s) psi_q <= psi_now;
			else if (power_good_out_q) psi_q <= psi_now;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			sidx_q <= '0;
			shed_q <= '0;
			adc_start <= 1'b0;
			adc_sel <= '0;
			load_current_sense_q <= '0;
		end else if (ce) begin
			adc_start <= 1'b0;
			if (seq_q == SEQ_STRAP) begin
				if (!busy_q) begin
					adc_start <= 1'b1;
					adc_sel <= sidx_q;
					busy_q <= 1'b1;
				end else if (adc_done) begin
					busy_q <= 1'b0;
					sidx_q <= sidx_q + 3'h1;
				end
			end else if (seq_q == SEQ_RUN) begin
				if (shed_q == 16'(`SHED_CYC - 1)) begin
					shed_q <= '0;
					if (!busy_q) begin
						adc_start <= 1'b1;
						adc_sel <= `SEL_LOAD_CURRENT_SENSE;
						busy_q <= 1'b1;
					end
				end else begin
					shed_q <= shed_q + 16'h1;
				end
				if (busy_q && adc_done) begin
					busy_q <= 1'b0;
					load_current_sense_q <= adc_data;
				end
			end else begin
				busy_q <= 1'b0;
				sidx_q <= '0;
				shed_q <= '0;
			end
		end
	end

	assign test_current_en = (seq_q == SEQ_STRAP);
	assign soft_start_ramp = (seq_q == SEQ_RAMP);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			zone_a_q <= `ZONE_RST;
			zone_b_q <= `ZONE_RST;
			th_q <= {4{`SHED_TH_OFF}};
			zcd_th_q <= `ZCD_TH_RST;
			zcd_ctl_q <= `ZCD_CTL_RST;
			ramp_sel_q <= '0;
			mask_q <= 8'hFF;
		end else if (ce) begin
			if (uvlo_s) begin
				zcd_ctl_q <= `ZCD_CTL_RST;
			end else if (strap_cap) begin
				if (sidx_q == `SEL_SOFT_BOOT_ZONE_STRAP) zone_b_q <= {5'h00, strap_zone(adc_data)};
				else if (sidx_q == `SEL_COLD_BOOT_ZONE_STRAP) zone_a_q <= {5'h00, strap_zone(adc_data)};
				else if (sidx_q == `SEL_RAMP) begin
					if (adc_data < `RB1) ramp_sel_q <= 2'h0;
					else if (adc_data < `RB2) ramp_sel_q <= 2'h1;
					else if (adc_data < `RB3) ramp_sel_q <= 2'h2;
					else ramp_sel_q <= 2'h3;
					mask_q <= ~csp_s;
				end else th_q[2'(sidx_q - 3'h2)] <= adc_data;
			end else if (wr_stb) begin
				if (ptr_q == `REG_ZONE_A) zone_a_q <= sh_q;
				else if (ptr_q == `REG_ZONE_B) zone_b_q <= sh_q;
				else if (ptr_q >= `REG_SHED_TH1 && ptr_q <= `REG_SHED_TH4) th_q[ptr_q[1:0]] <= sh_q;
				else if (ptr_q == `REG_ZCD_TH) zcd_th_q <= sh_q;
				else if (ptr_q == `REG_ZCD_CTL) zcd_ctl_q <= sh_q;
			end
		end
	end

	assign zif.power_save_select = psi_q;
	assign zif.shed_en = power_good_out_q;
	assign zif.load_current_sense = load_current_sense_q;
	assign zif.th = th_q;
	assign zif.cold = cold_q;
	assign zif.zone_a = zone_a_q[2:0];
	assign zif.zone_b = zone_b_q[2:0];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_en_q <= '0;
			de_q <= 1'b0;
			drive_q <= DRV_MID;
		end else if (ce) begin
			phase_en_q <= active ? (mask_q & zif.mask) : 8'h00;
			de_q <= (zif.zone == `ZONE_MAX);
			// Phase one stays parked mid until its enable output is up, so drive never leads the enable.
			if (!active || !phase_en_q[0]) drive_q <= DRV_MID;
			else if (first_phase_drive_on) drive_q <= DRV_HIGH;
			else if (zcd_ctl_q[`ZCD_EN_BIT]) begin
				// Diode emulation parks the low side off once the current reaches zero.
				drive_q <= (de_q && zcd_s) ? DRV_MID : DRV_LOW;
			end else begin
				drive_q <= zcd_ctl_q[`ZCD_OFF_MID_BIT] ? DRV_MID : DRV_LOW;
			end
		end
	end

	assign phase_enable = phase_en_q;
	assign diode_emulation = de_q && zcd_ctl_q[`ZCD_EN_BIT];
	assign first_phase_drive = drive_q;
	assign power_good_out = power_good_out_q;
	assign zcd_threshold = zcd_th_q;

	assign scl_rise = scl_s && !scl_d_q;
	assign scl_fall = !scl_s && scl_d_q;
	assign bus_start = scl_s && scl_d_q && sda_d_q && !sda_s;
	assign bus_stop = scl_s && scl_d_q && !sda_d_q && sda_s;
	assign wr_stb = (bus_q == BUS_RX) && scl_fall && (bcnt_q == 4'h8) && (bidx_q >= 2'h2);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else if (ce) begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	// Serial slave: address, register pointer, then data with auto-increment.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q <= BUS_IDLE;
			bcnt_q <= '0;
			bidx_q <= '0;
			sh_q <= '0;
			ptr_q <= '0;
			rw_q <= 1'b0;
		end else if (ce) begin
			if (bus_start) begin
				bus_q <= BUS_RX;
				bcnt_q <= '0;
				bidx_q <= '0;
			end else if (bus_stop) begin
				bus_q <= BUS_IDLE;
			end else begin
				unique case (bus_q)
					BUS_IDLE: bus_q <= BUS_IDLE;
					BUS_RX: begin
						if (scl_rise) begin
							sh_q <= {sh_q[6:0], sda_s};
							bcnt_q <= bcnt_q + 4'h1;
						end else if (scl_fall && bcnt_q == 4'h8) begin
							bcnt_q <= '0;
							if (bidx_q == 2'h0 && sh_q[7:1] != `I2C_ADDR) begin
								bus_q <= BUS_IDLE;
							end else begin
								bus_q <= BUS_ACK;
								if (bidx_q == 2'h0) rw_q <= sh_q[0];
								else if (bidx_q == 2'h1) ptr_q <= sh_q;
								else ptr_q <= ptr_q + 8'h01;
							end
						end
					end
					BUS_ACK: begin
						if (scl_fall) begin
							if (bidx_q != 2'h3) bidx_q <= bidx_q + 2'h1;
							if (rw_q) begin
								bus_q <= BUS_TX;
								sh_q <= rd_reg(ptr_q);
								ptr_q <= ptr_q + 8'h01;
							end else begin
								bus_q <= BUS_RX;
							end
						end
					end
					BUS_TX: begin
						if (scl_fall) begin
							sh_q <= {sh_q[6:0], 1'b1};
							bcnt_q <= bcnt_q + 4'h1;
							if (bcnt_q == 4'h7) begin
								bus_q <= BUS_RACK;
								bcnt_q <= '0;
							end
						end
					end
					BUS_RACK: begin
						if (scl_rise && sda_s) begin
							bus_q <= BUS_IDLE;
						end else if (scl_fall) begin
							bus_q <= BUS_TX;
							sh_q <= rd_reg(ptr_q);
							ptr_q <= ptr_q + 8'h01;
						end
					end
					default: bus_q <= BUS_IDLE;
				endcase
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = (bus_q == BUS_ACK) || ((bus_q == BUS_TX) && !sh_q[7]);
endmodule // phase_zone_sequencer
`default_nettype wire

// [common/phase_zone_defines.svh]
// Offsets, field positions, reset values and timing counts of the phase zone sequencer.
// Assumes a 20 MHz clock and an 8-bit strap and load current converter with a 2 V full scale.
`ifndef PHASE_ZONE_DEFINES_SVH
`define PHASE_ZONE_DEFINES_SVH
`define I2C_ADDR 7'h20
`define REG_PHASE_STAT 8'h30
`define REG_ZONE_A 8'h34
`define REG_ZONE_B 8'h36
`define REG_SHED_TH1 8'h38
`define REG_SHED_TH4 8'h3B
`define REG_ZCD_TH 8'h3C
`define REG_ZCD_CTL 8'h3D
`define REG_STATUS 8'h3E
`define ZCD_EN_BIT 0
`define ZCD_OFF_MID_BIT 1
`define ZCD_CTL_RST 8'h01
`define ZCD_TH_RST 8'h10
`define ZONE_RST 8'h00
`define SHED_TH_OFF 8'hFF
`define ZONE_MAX 3'h4
`define SEL_SOFT_BOOT_ZONE_STRAP 3'h0
`define SEL_COLD_BOOT_ZONE_STRAP 3'h1
`define SEL_RAMP 3'h6
`define SEL_LOAD_CURRENT_SENSE 3'h7
`define ZB1 8'h15
`define ZB2 8'h27
`define ZB3 8'h3B
`define ZB4 8'h55
`define RB1 8'h20
`define RB2 8'h40
`define RB3 8'h60
`define CLK_PERIOD_NS 50
`define SHED_PERIOD_NS 10000
`define SHED_CYC (`SHED_PERIOD_NS / `CLK_PERIOD_NS)
`define INIT_TIME_NS 500000
`define INIT_CYC (`INIT_TIME_NS / `CLK_PERIOD_NS)
`define RAMP_STEP_NS 1000000
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `CLK_PERIOD_NS)
`endif

// [common/phase_zone_pkg.sv]
// Types shared by the phase zone sequencer and its zone selector.
// Assumes nothing beyond a SystemVerilog compiler.
package phase_zone_pkg;
	typedef enum logic [5:0] {SEQ_OFF = 6'h01, SEQ_STRAP = 6'h02, SEQ_INIT = 6'h04,
		SEQ_RAMP = 6'h08, SEQ_RUN = 6'h10, SEQ_FAULT = 6'h20} seq_e;
	typedef enum logic [4:0] {BUS_IDLE = 5'h01, BUS_RX = 5'h02, BUS_ACK = 5'h04,
		BUS_TX = 5'h08, BUS_RACK = 5'h10} bus_e;
	typedef enum logic [2:0] {PSI_LOW = 3'h1, PSI_MID = 3'h2, PSI_HIGH = 3'h4} psi_e;
	typedef enum logic [1:0] {DRV_LOW = 2'h0, DRV_MID = 2'h1, DRV_HIGH = 2'h2} level_e;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] zone_t;
endpackage

// [common/zone_if.sv]
// Signals between the sequencer and its zone selector.
// Assumes both ends share one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface zone_if;
	import phase_zone_pkg::*;
	psi_e power_save_select;
	logic shed_en;
	byte_t load_current_sense;
	logic [3:0][7:0] th;
	logic cold;
	zone_t zone_a;
	zone_t zone_b;
	zone_t zone;
	logic [7:0] mask;
	modport ctrl(output power_save_select, shed_en, load_current_sense, th, cold, zone_a, zone_b, input zone, mask);
	modport sel(input power_save_select, shed_en, load_current_sense, th, cold, zone_a, zone_b, output zone, mask);
endinterface
`default_nettype wire

// [src/zone_select.sv]
// Combinational choice of power zone and the matching phase mask.
// Assumes its inputs come from registers of the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "phase_zone_defines.svh"
module zone_select (
	zone_if.sel zif
);
	import phase_zone_pkg::*;

	function automatic logic [7:0] zone_mask(input zone_t z);
		unique case (z)
			3'h0: zone_mask = 8'hFF;
			3'h1: zone_mask = 8'h55;
			3'h2: zone_mask = 8'h11;
			default: zone_mask = 8'h01;
		endcase
	endfunction

	function automatic logic shed_off(input byte_t t);
		shed_off = (t == `SHED_TH_OFF);
	endfunction

	zone_t z;

	always_comb begin
		z = 3'h0;
		unique case (zif.power_save_select)
			PSI_HIGH: z = 3'h0;
			PSI_MID: begin
				if (!zif.shed_en) z = 3'h0;
				else if (shed_off(zif.th[3]) || zif.load_current_sense > zif.th[3]) z = 3'h0;
				else if (shed_off(zif.th[2]) || zif.load_current_sense > zif.th[2]) z = 3'h1;
				else if (shed_off(zif.th[1]) || zif.load_current_sense > zif.th[1]) z = 3'h2;
				else if (shed_off(zif.th[0]) || zif.load_current_sense > zif.th[0]) z = 3'h3;
				else z = `ZONE_MAX;
			end
			PSI_LOW: z = zif.cold ? zif.zone_a : zif.zone_b;
			default: z = 3'h0;
		endcase
		if (z > `ZONE_MAX) z = `ZONE_MAX;
	end

	assign zif.zone = z;
	assign zif.mask = zone_mask(z);
endmodule // zone_select
`default_nettype wire

// [bench/phase_zone_chk.sv]
// Port checker of the phase zone sequencer, bound to every instance.
// Assumes one clock domain with the asynchronous high reset sys_rst.
`timescale 1ns/1ps
`default_nettype none
module phase_zone_chk
	import phase_zone_pkg::*;
#(
	parameter int INIT_CYC = 20,
	parameter int RAMP_STEP_CYC = 30
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic enable,
	input wire logic vcc_uvlo,
	input wire logic ramp_supply_sense,
	input wire logic ovp_fault,
	input wire logic uvp_fault,
	input wire logic first_phase_drive_on,
	input wire logic adc_start,
	input wire logic [2:0] adc_sel,
	input wire logic test_current_en,
	input wire logic power_good_out,
	input wire logic soft_start_ramp,
	input wire logic [7:0] phase_enable,
	input wire logic diode_emulation,
	input wire phase_zone_pkg::level_e first_phase_drive
);
	logic [7:0] cause_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Short history of every event that is allowed to lower power-good.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			cause_q <= 8'h00;
		else
			cause_q <= {cause_q[6:0], ovp_fault | uvp_fault | vcc_uvlo | !ramp_supply_sense | $rose(enable)};
	end
	chk_adc_one_pulse: assert property (adc_start |=> !adc_start)
		else $error("conversion request longer than one cycle");
	chk_strap_sel_range: assert property (adc_start && test_current_en |-> adc_sel != 3'h7)
		else $error("load current converted during strap measurement");
	chk_load_sel_run: assert property (adc_start && !test_current_en |-> adc_sel == 3'h7)
		else $error("strap converted outside strap measurement");
	chk_power_good_out_soft_low: assert property (soft_start_ramp || test_current_en |-> !power_good_out)
		else $error("power good high during soft start");
	chk_power_good_out_fall_cause: assert property ($fell(power_good_out) |-> cause_q != 8'h00)
		else $error("power good fell without a fault or restart");
	chk_drive_high_on: assert property (ce && first_phase_drive_on && power_good_out && phase_enable[0]
		|=> first_phase_drive == DRV_HIGH)
		else $error("phase one not driven high during on time");
	chk_drive_idle_mid: assert property (ce && !phase_enable[0] |=> first_phase_drive == DRV_MID)
		else $error("inactive phase one not parked mid");
	chk_de_single_phase: assert property (diode_emulation |-> phase_enable[7:1] == 7'h00)
		else $error("diode emulation with more than one phase");
	cov_power_good_out_rise: cover property ($rose(power_good_out));
	cov_de_on: cover property ($rose(diode_emulation));
	cov_drive_mid_run: cover property (power_good_out && first_phase_drive == DRV_MID);
endmodule // phase_zone_chk
bind phase_zone_sequencer phase_zone_chk #(.INIT_CYC(INIT_CYC), .RAMP_STEP_CYC(RAMP_STEP_CYC)) i_chk (
	.clk, .sys_rst, .ce, .enable, .vcc_uvlo, .ramp_supply_sense, .ovp_fault, .uvp_fault, .first_phase_drive_on,
	.adc_start, .adc_sel, .test_current_en, .power_good_out, .soft_start_ramp, .phase_enable,
	.diode_emulation, .first_phase_drive);
`default_nettype wire

// [bench/adc_partner.sv]
// Converter model: answers each request with a strap code or the load current.
// Assumes one request outstanding at a time, on the sequencer clock.
`timescale 1ns/1ps
`default_nettype none
module adc_partner
	import phase_zone_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic adc_start,
	input wire logic [2:0] adc_sel,
	input wire phase_zone_pkg::byte_t load_current_sense,
	input wire logic slow,
	output logic adc_done,
	output phase_zone_pkg::byte_t adc_data
);
	int cnt_q;
	logic [2:0] sel_q;
	byte_t val;
	// Soft zone 2, cold zone 4, thresholds floating, ramp of two steps.
	always_comb begin
		case (sel_q)
			3'h0: val = 8'h30;
			3'h1: val = 8'h60;
			3'h6: val = 8'h25;
			3'h7: val = load_current_sense;
			default: val = 8'hFF;
		endcase
	end
	// Between results the data toggles so a stale value never passes for a fresh one.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 0;
			sel_q <= 3'h0;
			adc_done <= 1'b0;
			adc_data <= 8'h00;
		end else begin
			adc_done <= cnt_q == 1;
			adc_data <= cnt_q == 1 ? val : ~adc_data;
			if (adc_start) begin
				cnt_q <= slow ? 12 : 3;
				sel_q <= adc_sel;
			end else if (cnt_q != 0) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
endmodule // adc_partner
`default_nettype wire

// [bench/tb_phase_zone_sequencer.sv]
// Bench of the phase zone sequencer: straps, soft start, zones, phase one drive, serial registers.
// Assumes the converter model on the strap and load sense path.
`timescale 1ns/1ps
`default_nettype none
`include "phase_zone_defines.svh"
module tb_phase_zone_sequencer;
	import phase_zone_pkg::*;
	localparam int INIT_N = 20;
	localparam int STEP_N = 30;
	logic clk = 1'b0, sys_rst = 1'b1, enable = 1'b0, vcc_uvlo = 1'b1, ovp_fault = 1'b0, in_regulation = 1'b0;
	logic psi_above_low = 1'b1, psi_above_mid = 1'b1, zero_current_detect = 1'b0, first_phase_drive_on = 1'b0;
	logic scl = 1'b1, sda_m = 1'b1, slow = 1'b0, sda_in, adc_start, adc_done, test_current_en;
	logic power_good_out, soft_start_ramp, diode_emulation, sda_out, sda_oe;
	logic [2:0] adc_sel;
	byte_t load_current_sense = 8'h00, adc_data, zcd_threshold, phase_enable, rd;
	level_e first_phase_drive;
	int n, cycles, straps, num_errors, comparisons;
	byte_t load[5] = '{8'h45, 8'h35, 8'h25, 8'h15, 8'h05};
	byte_t mask[5] = '{8'h3F, 8'h15, 8'h11, 8'h01, 8'h01};
	assign sda_in = sda_m & ~sda_oe;
	phase_zone_sequencer #(.INIT_CYC(INIT_N), .RAMP_STEP_CYC(STEP_N)) i_dut (.clk, .sys_rst, .ce(1'b1), .enable,
		.vcc_uvlo, .ramp_supply_sense(1'b1), .ovp_fault, .uvp_fault(1'b0), .in_regulation, .psi_above_low,
		.psi_above_mid, .zero_current_detect, .phase_sense_pos(8'hC0), .first_phase_drive_on, .adc_done, .adc_data,
		.scl_in(scl), .sda_in, .adc_start, .adc_sel, .test_current_en, .power_good_out, .soft_start_ramp,
		.phase_enable, .diode_emulation, .first_phase_drive, .zcd_threshold, .sda_out, .sda_oe);
	adc_partner i_adc (.clk, .sys_rst, .adc_start, .adc_sel, .load_current_sense, .slow, .adc_done, .adc_data);
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		straps += test_current_en;
		if (cycles == 40000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic chk8(input byte_t got, input byte_t exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bit_io(input logic b, output logic r);
		tick(3);
		sda_m <= b;
		tick(7);
		scl <= 1'b1;
		tick(5);
		r = sda_in;
		tick(5);
		scl <= 1'b0;
	endtask
	// A start when high is one, otherwise a stop that leaves both lines high.
	task automatic cond(input logic start);
		tick(3);
		sda_m <= start;
		tick(5);
		scl <= 1'b1;
		tick(8);
		sda_m <= !start;
		tick(8);
		scl <= !start;
	endtask
	task automatic send(input byte_t d, input logic ack, output byte_t r);
		logic b;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, b);
		chk8({7'h00, b}, {7'h00, !ack});
	endtask
	task automatic xfer(input logic rd_op, input byte_t a, input byte_t d);
		byte_t r;
		cond(1'b1);
		send({`I2C_ADDR, 1'b0}, 1'b1, r);
		send(a, 1'b1, r);
		if (rd_op) begin
			cond(1'b1);
			send({`I2C_ADDR, 1'b1}, 1'b1, r);
			send(8'hFF, 1'b0, r);
			chk8(r, d);
		end else begin
			send(d, 1'b1, r);
		end
		cond(1'b0);
	endtask
	initial begin
		tick(3);
		sys_rst <= 1'b0;
		tick(1);
		chk8(zcd_threshold, 8'h10);
		chk8({6'h00, first_phase_drive}, 8'h01);
		vcc_uvlo <= 1'b0;
		tick(6);
		enable <= 1'b1;
		for (n = 0; n < 100 && !test_current_en; n++) tick(1);
		for (n = 0; n < 300 && test_current_en; n++) tick(1);
		for (n = 0; n < 100 && !soft_start_ramp; n++) tick(1);
		chk8(byte_t'(n), byte_t'(INIT_N));
		psi_above_mid <= 1'b0;
		for (n = 0; n < 400 && soft_start_ramp; n++) tick(1);
		chk8(byte_t'(n), byte_t'(2 * STEP_N));
		chk8(phase_enable, 8'h3F);
		in_regulation <= 1'b1;
		for (n = 0; n < 20 && !power_good_out; n++) tick(1);
		chk8({7'h00, power_good_out}, 8'h01);
		xfer(1'b1, `REG_PHASE_STAT, 8'h3F);
		$display("startup test done");
		slow <= 1'b1;
		tick(450);
		chk8(phase_enable, 8'h3F);
		for (int i = 0; i < 4; i++)
			xfer(1'b0, byte_t'(8'h38 + i), byte_t'(8'h10 * (i + 1)));
		foreach (load[i]) begin
			load_current_sense <= load[i];
			tick(450);
			chk8(phase_enable, mask[i]);
		end
		psi_above_mid <= 1'b1;
		tick(10);
		chk8(phase_enable, 8'h3F);
		psi_above_mid <= 1'b0;
		tick(450);
		chk8(phase_enable, 8'h01);
		xfer(1'b0, `REG_SHED_TH4, `SHED_TH_OFF);
		tick(450);
		chk8(phase_enable, 8'h3F);
		$display("shedding test done");
		psi_above_low <= 1'b0;
		tick(10);
		chk8(phase_enable, 8'h01);
		chk8({7'h00, diode_emulation}, 8'h01);
		first_phase_drive_on <= 1'b1;
		tick(2);
		chk8({6'h00, first_phase_drive}, 8'h02);
		first_phase_drive_on <= 1'b0;
		zero_current_detect <= 1'b1;
		tick(6);
		chk8({6'h00, first_phase_drive}, 8'h01);
		zero_current_detect <= 1'b0;
		tick(6);
		chk8({6'h00, first_phase_drive}, 8'h00);
		xfer(1'b0, `REG_ZCD_CTL, 8'h00);
		chk8({7'h00, diode_emulation}, 8'h00);
		xfer(1'b0, `REG_ZCD_CTL, 8'h02);
		chk8({6'h00, first_phase_drive}, 8'h01);
		xfer(1'b1, `REG_ZCD_CTL, 8'h02);
		xfer(1'b0, `REG_ZCD_TH, 8'h2A);
		chk8(zcd_threshold, 8'h2A);
		xfer(1'b0, `REG_ZONE_A, 8'h02);
		chk8(phase_enable, 8'h11);
		xfer(1'b1, 8'h31, 8'h00);
		cond(1'b1);
		send(8'h42, 1'b0, rd);
		cond(1'b0);
		$display("fixed zone test done");
		ovp_fault <= 1'b1;
		tick(8);
		chk8({7'h00, power_good_out}, 8'h00);
		ovp_fault <= 1'b0;
		enable <= 1'b0;
		xfer(1'b0, `REG_ZONE_B, 8'h01);
		n = straps;
		enable <= 1'b1;
		for (int i = 0; i < 400 && !power_good_out; i++) tick(1);
		tick(10);
		chk8({7'h00, power_good_out}, 8'h01);
		chk8(byte_t'(straps - n), 8'h00);
		chk8(phase_enable, 8'h15);
		enable <= 1'b0;
		tick(10);
		chk8({7'h00, power_good_out}, 8'h01);
		$display("restart test done");
		end_of_test();
	end
endmodule // tb_phase_zone_sequencer
`default_nettype wire
